// ==== core/tss_consts.vh ====
`ifndef TSS_CONSTS_VH
`define TSS_CONSTS_VH

// Register word addresses (byte offsets, one 32-bit word each)
`define TSS_ADDR_CTRL 8'h00
`define TSS_ADDR_SRC_SIZE 8'h04
`define TSS_ADDR_SRC_EXCESS 8'h08
`define TSS_ADDR_WIN_SIZE 8'h0C
`define TSS_ADDR_PROG_SCALE 8'h10
`define TSS_ADDR_PHASE 8'h14
`define TSS_ADDR_SEAM_EXCESS 8'h18
`define TSS_ADDR_STATUS 8'h1C
`define TSS_ADDR_ACT_SCALE 8'h20
`define TSS_ADDR_STATS 8'h24

// Control field positions
`define TSS_CTRL_EN_BIT 0
`define TSS_CTRL_PROG_BIT 1
`define TSS_CTRL_START_BIT 2

// Phase register fields: 2.14 phase in low bits, trip bit above it
`define TSS_PHASE_W 16
`define TSS_PHASE_TRIP_BIT 31

// Scale factor format 2.14
`define TSS_SCALE_FRAC 14
`define TSS_SCALE_W 16

// Pixel geometry
`define TSS_SIZE_W 13
`define TSS_PPC 13'h0002
`define TSS_TAPS 7
`define TSS_CENTER_TAP 3

// Reset values
`define TSS_RST_SCALE 16'h4000
`define TSS_RST_SIZE 13'h0000

// Divider steps: quotient bits 16 down to 0
`define TSS_DIV_STEPS 5'h10

`endif

// ==== core/tss_divider.v ====
`timescale 1ns/1ps
`include "tss_consts.vh"

// Sequential restoring divider producing a rounded 2.14 quotient
module tss_divider (
    input wire clk_sys_i,
    input wire rst_i,
    input wire start_i,
    input wire [12:0] num_i,
    input wire [12:0] den_i,
    output reg [15:0] quot_o,
    output reg busy_o,
    output reg done_o
);
    // Numerator scaled by 2^15 for one guard bit used in rounding
    reg [27:0] rem_reg;
    reg [16:0] q_reg;
    reg [4:0] cnt_reg;
    reg [12:0] den_reg;
    reg sat_reg; // Quotient of four or more cannot fit 2.14
    wire [29:0] shifted; // Divisor moved up to the current quotient bit
    wire fits;
    wire [27:0] trial;
    wire [16:0] q_fin;
    wire [16:0] rounded;

    // Wide enough that a large divisor is never cut at the top
    assign shifted = {17'h0_0000, den_reg} << cnt_reg;
    assign fits = ({2'b00, rem_reg} >= shifted);
    // Only used when the divisor fits, so no bits are lost
    assign trial = rem_reg - shifted[27:0];
    // Last step: bit 0 is still in flight, so fold it in here
    assign q_fin = q_reg | {16'h0000, fits};
    // Round half up on the guard bit
    assign rounded = (q_fin >> 1) + {16'h0000, q_fin[0]};

    // Long division, one quotient bit per clock, MSB first
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rem_reg <= 28'h000_0000;
            q_reg <= 17'h0_0000;
            cnt_reg <= 5'h00;
            den_reg <= 13'h0000;
            sat_reg <= 1'b0;
            quot_o <= `TSS_RST_SCALE;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                // Divide by zero leaves the old factor untouched
                if (den_i != 13'h0000) begin
                    rem_reg <= {num_i, 15'h0000};
                    den_reg <= den_i;
                    q_reg <= 17'h0_0000;
                    cnt_reg <= `TSS_DIV_STEPS;
                    sat_reg <= ({2'b00, num_i} >= {den_i, 2'b00});
                    busy_o <= 1'b1;
                end
            end else if (busy_o) begin
                // Quotient bit set when shifted divisor fits
                if (fits) begin
                    rem_reg <= trial;
                    q_reg[cnt_reg] <= 1'b1;
                end
                if (cnt_reg == 5'h00) begin
                    // Result and done pulse leave together, saturated at 2.14 max
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    quot_o <= (sat_reg || rounded[16]) ? 16'hFFFF : rounded[15:0];
                end else begin
                    cnt_reg <= cnt_reg - 5'h01;
                end
            end
        end
    end
endmodule // tss_divider

// ==== core/tss_pixel_dropper.v ====
`timescale 1ns/1ps
`include "tss_consts.vh"

// End-of-pipe overlap dropper, works on pixel pairs
module tss_pixel_dropper (
    input wire clk_sys_i,
    input wire rst_i,
    input wire line_start_i,
    input wire pix_valid_i,
    input wire [47:0] pix_data_i,
    input wire seam_right_i,
    input wire [12:0] keep_i,
    input wire [12:0] drop_i,
    output reg pix_valid_o,
    output reg [47:0] pix_data_o,
    output reg [12:0] dropped_o
);
    // Pixel-pair position within the scaler output line
    reg [11:0] grp_reg;
    wire [11:0] drop_grp;
    wire [11:0] keep_grp;
    wire in_drop;

    // Whole groups only; odd low bits of an amount are ignored
    assign drop_grp = drop_i[12:1];
    assign keep_grp = keep_i[12:1];
    // Right pipe drops its leading groups, left pipe its trailing ones
    assign in_drop = seam_right_i ? (grp_reg < drop_grp) : (grp_reg >= keep_grp);

    // Gate groups and count discarded pixels per line
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            grp_reg <= 12'h000;
            pix_valid_o <= 1'b0;
            pix_data_o <= 48'h0000_0000_0000;
            dropped_o <= 13'h0000;
        end else begin
            pix_valid_o <= 1'b0;
            if (line_start_i) begin
                grp_reg <= 12'h000;
                dropped_o <= 13'h0000;
            end else if (pix_valid_i) begin
                grp_reg <= grp_reg + 12'h001;
                if (in_drop) begin
                    dropped_o <= dropped_o + `TSS_PPC;
                end else begin
                    pix_valid_o <= 1'b1;
                    pix_data_o <= pix_data_i;
                end
            end
        end
    end
endmodule // tss_pixel_dropper

// ==== core/tss_seam_scaler.v ====
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "tss_consts.vh"

module tss_seam_scaler (
    input wire clk_sys_i,
    input wire rst_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    input wire line_start_i,
    input wire pix_valid_i,
    input wire [47:0] pix_data_i,
    input wire seam_right_i,
    output wire pix_valid_o,
    output wire [47:0] pix_data_o,
    output reg [28:0] phase_acc_o,
    output reg [15:0] scale_o,
    output wire busy_o
);
    // Software-owned configuration, then the derived factor and line count
    reg enable_reg; // Scaler on
    reg prog_mode_reg; // Use programmed factor
    reg [12:0] src_size_reg; // S
    reg [12:0] src_excess_reg; // Source overlap
    reg [12:0] win_size_reg; // D plus destination overlap
    reg [15:0] programmed_horizontal_scale; // 2.14 target
    reg [15:0] phase_cfg_reg; // 2.14 initial phase
    reg phase_trip_reg; // Initial phase trip bit
    reg [12:0] seam_excess_reg; // Destination overlap to drop
    reg [15:0] derived_scale_reg; // Last hardware factor
    reg [15:0] line_count_reg; // Lines started while enabled
    reg calc_start_reg; // Divider kick

    wire [12:0] dest_size; // D without overlap
    wire [12:0] num_sum;
    wire [15:0] div_quot;
    wire div_busy;
    wire div_done;
    wire [12:0] dropped;
    wire [15:0] active_scale;
    wire [28:0] init_phase;
    wire upscale;

    // Add two sizes, cut back to size width
    function [12:0] tss_add;
        input [12:0] a;
        input [12:0] b;
        reg [13:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            tss_add = s[12:0];
        end
    endfunction

    // Does an address match a register word
    function tss_hit;
        input [7:0] a;
        input [7:0] r;
        begin
            tss_hit = (a == r);
        end
    endfunction

    // Destination width excludes overlap that will be dropped
    assign dest_size = win_size_reg - seam_excess_reg;
    // Hardware-derived factor numerator: S plus source overlap
    assign num_sum = tss_add(src_size_reg, src_excess_reg);
    // Output wider than source means upscaling; factor below one
    assign upscale = (win_size_reg > num_sum);
    // Programmed factor wins when its mode bit is set
    assign active_scale = prog_mode_reg ? programmed_horizontal_scale : derived_scale_reg;
    // Without trip, the programmed phase is not applied
    assign init_phase = phase_trip_reg ? {13'h0000, phase_cfg_reg} : 29'h0000_0000;
    assign busy_o = div_busy;

    // Register writes; divider launch on a control write with the start bit set
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            enable_reg <= 1'b0;
            prog_mode_reg <= 1'b0;
            src_size_reg <= `TSS_RST_SIZE;
            src_excess_reg <= `TSS_RST_SIZE;
            win_size_reg <= `TSS_RST_SIZE;
            programmed_horizontal_scale <= `TSS_RST_SCALE;
            phase_cfg_reg <= 16'h0000;
            phase_trip_reg <= 1'b0;
            seam_excess_reg <= `TSS_RST_SIZE;
            calc_start_reg <= 1'b0;
        end else begin
            calc_start_reg <= 1'b0;
            if (wr_i) begin
                if (tss_hit(addr_i, `TSS_ADDR_CTRL)) begin
                    enable_reg <= wdata_i[`TSS_CTRL_EN_BIT];
                    prog_mode_reg <= wdata_i[`TSS_CTRL_PROG_BIT];
                    calc_start_reg <= wdata_i[`TSS_CTRL_START_BIT];
                end
                if (tss_hit(addr_i, `TSS_ADDR_SRC_SIZE)) begin
                    src_size_reg <= wdata_i[12:0];
                end
                if (tss_hit(addr_i, `TSS_ADDR_SRC_EXCESS)) begin
                    src_excess_reg <= wdata_i[12:0];
                end
                if (tss_hit(addr_i, `TSS_ADDR_WIN_SIZE)) begin
                    win_size_reg <= wdata_i[12:0];
                end
                if (tss_hit(addr_i, `TSS_ADDR_PROG_SCALE)) begin
                    programmed_horizontal_scale <= wdata_i[15:0];
                end
                if (tss_hit(addr_i, `TSS_ADDR_PHASE)) begin
                    phase_cfg_reg <= wdata_i[15:0];
                    phase_trip_reg <= wdata_i[`TSS_PHASE_TRIP_BIT];
                end
                if (tss_hit(addr_i, `TSS_ADDR_SEAM_EXCESS)) begin
                    seam_excess_reg <= wdata_i[12:0];
                end
            end
        end
    end

    // Hardware factor (S + overlap) / (D + overlap), rounded 2.14
    tss_divider u_div (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .start_i(calc_start_reg),
        .num_i(num_sum),
        .den_i(win_size_reg),
        .quot_o(div_quot),
        .busy_o(div_busy),
        .done_o(div_done)
    );

    // Capture the divider result as the derived factor
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            derived_scale_reg <= `TSS_RST_SCALE;
        end else if (div_done) begin
            // Only a finished division replaces the factor
            derived_scale_reg <= div_quot;
        end
    end

    // Horizontal phase walk: line begins at centre tap plus initial phase
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phase_acc_o <= 29'h0000_0000;
            scale_o <= `TSS_RST_SCALE;
            line_count_reg <= 16'h0000;
        end else begin
            scale_o <= active_scale;
            if (line_start_i && enable_reg) begin
                // Source pixel 0 sits in the centre tap; only forward phase
                phase_acc_o <= init_phase;
                line_count_reg <= line_count_reg + 16'h0001;
            end else if (pix_valid_i && enable_reg) begin
                // Two output pixels per clock advance by twice the factor
                phase_acc_o <= phase_acc_o + {12'h000, active_scale, 1'b0};
            end
        end
    end

    // Overlap dropper at the pipe outlet
    tss_pixel_dropper u_drop (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .line_start_i(line_start_i),
        .pix_valid_i(pix_valid_i & enable_reg),
        .pix_data_i(pix_data_i),
        .seam_right_i(seam_right_i),
        .keep_i(dest_size),
        .drop_i(seam_excess_reg),
        .pix_valid_o(pix_valid_o),
        .pix_data_o(pix_data_o),
        .dropped_o(dropped)
    );

    // Read mux, data one cycle after the strobe; unmapped reads zero
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                `TSS_ADDR_CTRL: rdata_o <= {30'h0000_0000, prog_mode_reg, enable_reg};
                `TSS_ADDR_SRC_SIZE: rdata_o <= {19'h0_0000, src_size_reg};
                `TSS_ADDR_SRC_EXCESS: rdata_o <= {19'h0_0000, src_excess_reg};
                `TSS_ADDR_WIN_SIZE: rdata_o <= {19'h0_0000, win_size_reg};
                `TSS_ADDR_PROG_SCALE: rdata_o <= {16'h0000, programmed_horizontal_scale};
                `TSS_ADDR_PHASE: rdata_o <= {phase_trip_reg, 15'h0000, phase_cfg_reg};
                `TSS_ADDR_SEAM_EXCESS: rdata_o <= {19'h0_0000, seam_excess_reg};
                // Status: busy, upscale, done never latched
                `TSS_ADDR_STATUS: rdata_o <= {30'h0000_0000, upscale, div_busy};
                `TSS_ADDR_ACT_SCALE: rdata_o <= {16'h0000, active_scale};
                `TSS_ADDR_STATS: rdata_o <= {line_count_reg, 3'h0, dropped};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // tss_seam_scaler

// ==== tb/tss_seam_scaler_properties.sv ====
`timescale 1ns/1ps
`include "tss_consts.vh"

// Port-level checker for the seam scaler
module tss_seam_props (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic line_start_i,
    input wire logic pix_valid_i,
    input wire logic [47:0] pix_data_i,
    input wire logic seam_right_i,
    input wire logic pix_valid_o,
    input wire logic [47:0] pix_data_o,
    input wire logic [28:0] phase_acc_o,
    input wire logic [15:0] scale_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // Divider start is refused on a zero window, so track it
    logic den_nz_reg;
    // Shadows of control and phase writes, seen from the bus only
    logic en_sh_reg;
    logic prog_sh_reg;
    logic trip_sh_reg;
    logic [15:0] phase_sh_reg;
    logic [28:0] phase_init_sh;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            den_nz_reg <= 1'b0;
            en_sh_reg <= 1'b0;
            prog_sh_reg <= 1'b0;
            trip_sh_reg <= 1'b0;
            phase_sh_reg <= 16'h0000;
        end else if (wr_i) begin
            if (addr_i == `TSS_ADDR_WIN_SIZE) begin
                den_nz_reg <= |wdata_i[12:0];
            end
            if (addr_i == `TSS_ADDR_CTRL) begin
                en_sh_reg <= wdata_i[`TSS_CTRL_EN_BIT];
                prog_sh_reg <= wdata_i[`TSS_CTRL_PROG_BIT];
            end
            if (addr_i == `TSS_ADDR_PHASE) begin
                phase_sh_reg <= wdata_i[15:0];
                trip_sh_reg <= wdata_i[`TSS_PHASE_TRIP_BIT];
            end
        end
    end
    // Phase that a line start should load
    assign phase_init_sh = trip_sh_reg ? {13'h0000, phase_sh_reg} : 29'h0000_0000;

    // Start request accepted while idle
    sequence s_calc_start;
        wr_i && addr_i == `TSS_ADDR_CTRL && wdata_i[0] && wdata_i[2] && !busy_o && den_nz_reg;
    endsequence
    // Write of source size, idle cycle, read of it
    sequence s_size_wr_rd;
        wr_i && addr_i == `TSS_ADDR_SRC_SIZE ##1 !wr_i ##1 rd_i && !wr_i && addr_i == `TSS_ADDR_SRC_SIZE;
    endsequence

    chk_calc_goes_busy: assert property (s_calc_start |-> ##2 busy_o)
        else $error("divider did not start");
    chk_calc_bounded: assert property ($rose(busy_o) |-> ##[1:40] !busy_o)
        else $error("divider ran too long");
    chk_size_readback: assert property (s_size_wr_rd |=> rdata_o[12:0] == $past(wdata_i[12:0], 3))
        else $error("source size readback wrong");
    chk_rdata_holds: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (rd_i && addr_i > `TSS_ADDR_STATS |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_ctrl_readback: assert property (rd_i && addr_i == `TSS_ADDR_CTRL |=>
        rdata_o == {30'h0000_0000, prog_sh_reg, en_sh_reg})
        else $error("control readback wrong");
    chk_kept_has_cause: assert property (pix_valid_o |-> $past(pix_valid_i))
        else $error("output pair without input pair");
    chk_kept_data: assert property (pix_valid_o |-> pix_data_o == $past(pix_data_i))
        else $error("kept pair data changed");
    chk_phase_load: assert property (line_start_i && en_sh_reg |=> phase_acc_o == $past(phase_init_sh))
        else $error("line start phase wrong");
endmodule // tss_seam_props

bind tss_seam_scaler tss_seam_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .line_start_i(line_start_i),
    .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i), .seam_right_i(seam_right_i),
    .pix_valid_o(pix_valid_o), .pix_data_o(pix_data_o), .phase_acc_o(phase_acc_o),
    .scale_o(scale_o), .busy_o(busy_o));

// ==== tb/tss_seam_scaler_test.sv ====
`timescale 1ns/1ps
`include "tss_consts.vh"

// Register-level bench for the seam scaler
module tss_seam_scaler_test;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic line_start_i = 1'b0;
    logic pix_valid_i = 1'b0;
    logic [47:0] pix_data_i = 48'h0000_0000_0000;
    logic seam_right_i = 1'b0;
    logic [31:0] rdata_o;
    logic pix_valid_o;
    logic [47:0] pix_data_o;
    logic [28:0] phase_acc_o;
    logic [15:0] scale_o;
    logic busy_o;
    integer num_errors = 0;
    integer tests_run = 0;
    integer kept = 0; // Pairs that survived the dropper

    // Worked upscale example, plane starting at the left edge
    localparam int PLANE_POS = 0;
    localparam int SRC_S = 960;
    localparam int SRC_X = (((7 - 1) / 2 + 1) / 2) * 2; // Half of taps less one, to a pair
    localparam int LEFT_PART = SRC_S - PLANE_POS;
    localparam int SURF_W = LEFT_PART + SRC_X; // Rotation 0 surface width
    localparam int DST_D = 2576;
    // Rounded destination overlap, then up to a whole pair
    localparam int DST_X = ((SURF_W * DST_D + SRC_S / 2) / SRC_S - DST_D + 1) / 2 * 2;
    localparam int WIN_X = DST_D + DST_X;
    // Rounded 2.14 factors: derived and target
    localparam int SF_ACT = ((SURF_W << 14) + WIN_X / 2) / WIN_X;
    localparam int SF_TGT = ((SRC_S << 14) + DST_D / 2) / DST_D;
    // Rotation 90 right start row; with the plane at zero also the first right pixel
    localparam int RIGHT_Y90 = LEFT_PART - SRC_X;
    // Positive distance, so the left scaler leads
    localparam int HORIZONTAL_INITIAL_PHASE = (RIGHT_Y90 << 14) - SF_ACT * (DST_D - DST_X);

    // 40 MHz system clock
    always #12.5 clk_sys_i = ~clk_sys_i;

    tss_seam_scaler dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .line_start_i(line_start_i),
        .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i), .seam_right_i(seam_right_i),
        .pix_valid_o(pix_valid_o), .pix_data_o(pix_data_o), .phase_acc_o(phase_acc_o),
        .scale_o(scale_o), .busy_o(busy_o));

    // Count kept pairs at each edge
    always @(posedge clk_sys_i) begin
        if (pix_valid_o === 1'b1) begin
            kept = kept + 1;
        end
    end

    task automatic close_out;
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    // One-cycle read, data looked at in the following cycle only
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        check(name, rdata_o, exp);
    endtask

    // Bounded wait for the divider to finish
    task automatic wait_idle;
        integer k;
        repeat (3) @(posedge clk_sys_i);
        #1;
        check("busy", {31'h0, busy_o}, 32'h0000_0001);
        for (k = 0; k < 100 && busy_o !== 1'b0; k = k + 1) begin
            @(posedge clk_sys_i);
            #1;
        end
        if (k == 100) begin
            num_errors = num_errors + 1;
            close_out;
        end
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask

    // Pulse a line start, then stream n pairs
    task automatic line(input logic right, input integer n);
        integer i;
        @(posedge clk_sys_i);
        seam_right_i <= right;
        line_start_i <= 1'b1;
        @(posedge clk_sys_i);
        line_start_i <= 1'b0;
        #1;
        kept = 0;
        for (i = 0; i < n; i = i + 1) begin
            @(posedge clk_sys_i);
            pix_valid_i <= 1'b1;
            pix_data_i <= 48'h0000_0000_0100 + i;
        end
        @(posedge clk_sys_i);
        pix_valid_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask

    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        check("scale reset", {16'h0, scale_o}, 32'h0000_4000);
        // Sizes of the worked upscale example
        wr(`TSS_ADDR_SRC_SIZE, SRC_S);
        rd(`TSS_ADDR_SRC_SIZE, SRC_S, "src size");
        wr(`TSS_ADDR_SRC_EXCESS, SRC_X);
        wr(`TSS_ADDR_WIN_SIZE, WIN_X);
        rd(8'h30, 32'h0000_0000, "unmapped");
        wr(`TSS_ADDR_CTRL, 32'h0000_0005);
        wait_idle();
        // Derived factor (S+Sx)/(D+Dx), rounded half up to 2.14
        check("derived", {16'h0, scale_o}, SF_ACT);
        rd(`TSS_ADDR_ACT_SCALE, SF_ACT, "act scale");
        rd(`TSS_ADDR_STATUS, 32'h0000_0002, "upscale");
        rd(`TSS_ADDR_CTRL, 32'h0000_0001, "ctrl");
        // Programmed target factor S/D replaces the derived one
        wr(`TSS_ADDR_PROG_SCALE, SF_TGT);
        wr(`TSS_ADDR_CTRL, 32'h0000_0003);
        repeat (2) @(posedge clk_sys_i);
        #1;
        check("programmed", {16'h0, scale_o}, SF_TGT);
        // Phase without trip bit must not apply
        wr(`TSS_ADDR_PHASE, HORIZONTAL_INITIAL_PHASE);
        line(1'b0, 0);
        check("phase no trip", {3'h0, phase_acc_o}, 32'h0000_0000);
        wr(`TSS_ADDR_PHASE, 32'h8000_0000 | HORIZONTAL_INITIAL_PHASE); // Left side leads
        @(posedge clk_sys_i);
        line_start_i <= 1'b1;
        @(posedge clk_sys_i);
        line_start_i <= 1'b0;
        #1;
        check("phase trip", {3'h0, phase_acc_o}, HORIZONTAL_INITIAL_PHASE);
        // Left pipe keeps (10-4)/2 pairs, right drops 5/2 leading pairs rounded down
        wr(`TSS_ADDR_WIN_SIZE, 32'h0000_000A);
        wr(`TSS_ADDR_SEAM_EXCESS, 32'h0000_0004);
        line(1'b0, 5); // No left border, window at zero
        check("left kept", kept, 3);
        check("phase walk", {3'h0, phase_acc_o}, HORIZONTAL_INITIAL_PHASE + 5 * 2 * SF_TGT);
        wr(`TSS_ADDR_SEAM_EXCESS, 32'h0000_0005);
        line(1'b1, 5); // Right pipe at zero position
        check("right kept", kept, 3);
        // Four lines so far, two leading pairs dropped on the last
        rd(`TSS_ADDR_STATS, 32'h0004_0004, "stats");
        close_out;
    end
endmodule // tss_seam_scaler_test
